// [bench/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int         MS  = 10;
    localparam logic [7:0] REV = 8'hC3; // Arbitrary value.
    logic                        clk;
    logic                        rst;
    load_diag_pkg::reg_write_s   wr;
    logic [7:0]                  rd_addr;
    logic                        range_sel;
    logic [3:0]                  go;
    logic [3:0]                  hiz;
    logic                        judge_off;
    logic                        real_only;
    logic [7:0]                  thresh;
    logic [3:0]                  valid;
    load_diag_pkg::load_result_s res [4];
    logic                        trip;
    logic [7:0]                  rd_data;
    logic [3:0]                  start;
    logic                        fclr;
    logic [31:0]                 settle;
    logic                        shut;
    logic                        pull_en;
    logic [15:0]                 mohm;
    int                          n_errors;
    int                          compares;
    int                          ms_tab [4];
    load_diag_report_misc_regs #(.REVISION_CODE(REV), .SETTLE_MS_CYCLES(MS)) dut (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_wr(wr), .i_rd_addr(rd_addr),
        .i_measure_range_select(range_sel), .i_measure_go(go), .i_channel_hiz(hiz),
        .i_small_speaker_judgement_off(judge_off), .i_magnitude_type_real_only(real_only),
        .i_small_speaker_threshold(thresh), .i_result_valid(valid), .i_result(res),
        .i_thermal_trip(trip), .o_rd_data(rd_data), .o_measure_start(start),
        .o_fault_clear(fclr), .o_settle_cycles(settle), .o_thermal_shutdown(shut),
        .o_gpio_pullup_en(pull_en), .o_mohm_per_code(mohm));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr = '{1'b1, a, d};
        @(negedge clk);
        wr.write_en = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        rd_addr = a;
        @(negedge clk);
        chk(rd_data, exp);
    endtask : rd_reg
    task automatic load(input int c, input logic [7:0] r, input logic [7:0] x);
        res[c] = '{r, x};
        valid[c] = 1'b1;
        @(negedge clk);
        valid = 4'h0;
    endtask : load
    task automatic final_report();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    initial begin
        #100000;
        n_errors++;
        final_report();
    end
    initial begin
        ms_tab = '{load_diag_pkg::SETTLE_MS_0, load_diag_pkg::SETTLE_MS_1,
                   load_diag_pkg::SETTLE_MS_2, load_diag_pkg::SETTLE_MS_3};
        rst = 1'b1; wr = '0; rd_addr = 8'h00; range_sel = 1'b0; go = 4'h0; hiz = 4'h0;
        judge_off = 1'b0; thresh = 8'h20; valid = 4'h0; trip = 1'b0; real_only = 1'b1;
        n_errors = 0; compares = 0;
        res = '{default: '0};
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk(pull_en, 1);
        for (int a = 8'h2A; a <= 8'h31; a++) rd_reg(a[7:0], 8'h00);
        rd_reg(load_diag_pkg::SILICON_REVISION_OFS, REV);
        repeat (2) @(negedge clk);
        chk(mohm, load_diag_pkg::RANGE0_MOHM_PER_CODE);
        range_sel = 1'b1;
        repeat (2) @(negedge clk);
        chk(mohm, load_diag_pkg::RANGE1_MOHM_PER_CODE);
        load(0, 8'h01, 8'h11); load(1, 8'h10, 8'hE5); load(2, 8'h40, 8'h1A); load(3, 8'h05, 8'h7F);
        rd_reg(load_diag_pkg::CH2_LOAD_IMAG_OFS, 8'hE5);
        rd_reg(load_diag_pkg::CH3_LOAD_REAL_OFS, 8'h40);
        rd_reg(load_diag_pkg::CH3_LOAD_IMAG_OFS, 8'h1A);
        rd_reg(load_diag_pkg::CH4_LOAD_REAL_OFS, 8'h05);
        rd_reg(load_diag_pkg::CH4_LOAD_IMAG_OFS, 8'h7F);
        rd_reg(load_diag_pkg::SMALL_SPEAKER_FLAGS_OFS, 8'h0D);
        judge_off = 1'b1;
        load(3, 8'h50, 8'h00);
        rd_reg(load_diag_pkg::SMALL_SPEAKER_FLAGS_OFS, 8'h0D);
        // Magnitude with half the decomplemented reactance: 0x10 + 0x10 is not below 0x20.
        judge_off = 1'b0;
        real_only = 1'b0;
        load(0, 8'h10, 8'hDF);
        rd_reg(load_diag_pkg::SMALL_SPEAKER_FLAGS_OFS, 8'h05);
        load(0, 8'h10, 8'hE1);
        rd_reg(load_diag_pkg::SMALL_SPEAKER_FLAGS_OFS, 8'h0D);
        wr_reg(8'h2D, 8'hFF);
        rd_reg(load_diag_pkg::CH4_LOAD_REAL_OFS, 8'h50);
        for (int k = 0; k < 4; k++) begin
            wr_reg(8'h30, {2'b10, k[1:0], 4'b0010});
            chk(fclr, 1);
            @(negedge clk);
            chk(fclr, 0);
            chk(settle, ms_tab[k] * MS);
            chk(pull_en, 0);
            rd_reg(load_diag_pkg::MISC_CONTROL_THREE_OFS, {2'b00, k[1:0], 4'b0010});
        end
        wr_reg(8'h30, 8'h00);
        chk(fclr, 0);
        chk(pull_en, 1);
        trip = 1'b1;
        @(negedge clk);
        trip = 1'b0;
        repeat (3) @(negedge clk);
        chk(shut, 1);
        wr_reg(8'h30, 8'h80);
        repeat (2) @(negedge clk);
        chk(shut, 0);
        wr_reg(8'h30, 8'h08);
        trip = 1'b1;
        repeat (2) @(negedge clk);
        chk(shut, 1);
        trip = 1'b0;
        repeat (2) @(negedge clk);
        chk(shut, 0);
        go = 4'h2;
        repeat (3) @(negedge clk) chk(start, 4'h0);
        hiz = 4'h2;
        for (int n = 0; n < 4 && start !== 4'h2; n++) @(negedge clk);
        chk(start, 4'h2);
        @(negedge clk);
        chk(start, 4'h0);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rd_reg(load_diag_pkg::SMALL_SPEAKER_FLAGS_OFS, 8'h00);
        rd_reg(load_diag_pkg::CH3_LOAD_REAL_OFS, 8'h00);
        final_report();
    end
endmodule : testbench
`default_nettype wire

// [common/load_diag_pkg.sv]
`default_nettype none
package load_diag_pkg;
    localparam logic [7:0] CH2_LOAD_IMAG_OFS       = 8'h2A;
    localparam logic [7:0] CH3_LOAD_REAL_OFS       = 8'h2B;
    localparam logic [7:0] CH3_LOAD_IMAG_OFS       = 8'h2C;
    localparam logic [7:0] CH4_LOAD_REAL_OFS       = 8'h2D;
    localparam logic [7:0] CH4_LOAD_IMAG_OFS       = 8'h2E;
    localparam logic [7:0] SMALL_SPEAKER_FLAGS_OFS = 8'h2F;
    localparam logic [7:0] MISC_CONTROL_THREE_OFS  = 8'h30;
    localparam logic [7:0] SILICON_REVISION_OFS    = 8'h32;
    localparam logic [7:0] REPORT_RESET            = 8'h00;
    localparam logic [7:0] MISC_RESET              = 8'h00;
    localparam int         FAULT_CLEAR_BIT         = 7;
    localparam int         SETTLE_LSB              = 4;
    localparam int         SELF_RESUME_BIT         = 3;
    localparam int         PULLUP_OFF_BIT          = 1;
    // Settle delays in ms, selected by the two-bit field code.
    localparam int         SETTLE_MS_0             = 20;
    localparam int         SETTLE_MS_1             = 15;
    localparam int         SETTLE_MS_2             = 40;
    localparam int         SETTLE_MS_3             = 50;
    localparam int         CLK_MHZ                 = 250;
    localparam int         CYCLES_PER_MS           = CLK_MHZ * 1000;
    // Result scaling in milliohm per code step.
    localparam int         RANGE0_MOHM_PER_CODE    = 800;
    localparam int         RANGE1_MOHM_PER_CODE    = 100;

    typedef struct packed {
        logic [7:0] resistance;
        logic [7:0] reactance;
    } load_result_s;

    typedef struct packed {
        logic       write_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_write_s;
endpackage : load_diag_pkg
`default_nettype wire

// [rtl/load_diag_report_misc_regs.sv]
// What this block does
// - Channels 3 and 4 measured load resistance is readable, resetting to zero.
// - Channels 2 to 4 complemented load reactance is readable separately.
// - Range select zero scales results and threshold at 0.8 ohm per code.
// - Range select one scales results and threshold at 0.1 ohm per code.
// - Four small-speaker flags, channel 1 at bit 3; upper bits read zero.
// - Writing 1 to the fault-clear bit clears latched faults; 0 does nothing.
// - Settle delay code selects 20, 15, 40 or 50 ms.
// - Self-resume bit set restarts after thermal trip; clear waits for fault clear.
// - Pull-up bit 0 enables open-drain pull-ups, 1 disables them.
// - A measurement starts only after its channel is in high impedance.
// - With judgement enabled, a magnitude below threshold sets the channel flag.
`timescale 1ns/10ps
`default_nettype none
module load_diag_report_misc_regs #(
    parameter logic [7:0] REVISION_CODE = 8'h5A, // Arbitrary value.
    parameter int         SETTLE_MS_CYCLES = load_diag_pkg::CYCLES_PER_MS
) (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_sys_rst,
    input  wire load_diag_pkg::reg_write_s  i_wr,
    input  wire logic [7:0]                 i_rd_addr,
    input  wire logic                       i_measure_range_select,
    input  wire logic [3:0]                 i_measure_go,
    input  wire logic [3:0]                 i_channel_hiz,
    input  wire logic                       i_small_speaker_judgement_off,
    input  wire logic                       i_magnitude_type_real_only,
    input  wire logic [7:0]                 i_small_speaker_threshold,
    input  wire logic [3:0]                 i_result_valid,
    input  wire load_diag_pkg::load_result_s i_result [4],
    input  wire logic                       i_thermal_trip,
    output logic [7:0]                      o_rd_data,
    output logic [3:0]                      o_measure_start,
    output logic                            o_fault_clear,
    output logic [31:0]                     o_settle_cycles,
    output logic                            o_thermal_shutdown,
    output logic                            o_gpio_pullup_en,
    output logic [15:0]                     o_mohm_per_code
);
    load_diag_pkg::load_result_s result [4];
    load_diag_pkg::load_result_s next_result [4];
    logic [3:0]  flags;
    logic [3:0]  next_flags;
    logic [7:0]  misc;
    logic [7:0]  next_misc;
    logic [3:0]  started;
    logic [3:0]  next_started;
    logic        thermal_sd;
    logic        next_thermal_sd;
    logic        fault_clr;
    logic        next_fault_clr;
    logic [7:0]  rd_data;
    logic [7:0]  next_rd_data;
    logic [31:0] settle;
    logic [31:0] next_settle;
    logic [15:0] scale;
    logic [15:0] next_scale;
    logic [3:0]  start_pulse;
    logic [3:0]  next_start_pulse;
    logic        pullup_en;
    logic        next_pullup_en;
    logic        write_misc;

    // Type 2 magnitude adds half the reactance; the stored field is its complement.
    function automatic logic [9:0] magnitude(input load_diag_pkg::load_result_s r,
                                              input logic real_only);
        logic [7:0] imag;
        imag = ~r.reactance;
        magnitude = real_only ? {2'b00, r.resistance}
                              : {2'b00, r.resistance} + {3'b000, imag[7:1]};
    endfunction : magnitude

    function automatic logic [31:0] settle_for(input logic [1:0] code);
        int ms;
        case (code)
            2'h0:    ms = load_diag_pkg::SETTLE_MS_0;
            2'h1:    ms = load_diag_pkg::SETTLE_MS_1;
            2'h2:    ms = load_diag_pkg::SETTLE_MS_2;
            default: ms = load_diag_pkg::SETTLE_MS_3;
        endcase
        settle_for = 32'(ms * SETTLE_MS_CYCLES);
    endfunction : settle_for

    assign write_misc = i_wr.write_en && i_wr.addr == load_diag_pkg::MISC_CONTROL_THREE_OFS;

    always_comb begin
        next_misc        = misc;
        next_fault_clr   = 1'b0;
        next_thermal_sd  = thermal_sd;
        next_started     = started;
        next_start_pulse = 4'h0;
        next_flags       = flags;
        for (int c = 0; c < 4; c++) begin
            next_result[c] = result[c];
        end
        if (write_misc) begin
            next_misc = i_wr.wdata & 8'h7F;
            next_fault_clr = i_wr.wdata[load_diag_pkg::FAULT_CLEAR_BIT];
        end
        // A trip in the clear cycle wins, so a fresh fault is never lost.
        if (i_thermal_trip) begin
            next_thermal_sd = 1'b1;
        end else if (thermal_sd && (misc[load_diag_pkg::SELF_RESUME_BIT] || fault_clr)) begin
            next_thermal_sd = 1'b0;
        end
        for (int c = 0; c < 4; c++) begin
            if (!i_measure_go[c]) begin
                next_started[c] = 1'b0;
            end else if (i_channel_hiz[c] && !started[c]) begin
                next_started[c] = 1'b1;
                next_start_pulse[c] = 1'b1;
            end
            if (i_result_valid[c]) begin
                next_result[c] = i_result[c];
                // Flag bit 3 belongs to channel 1, so index is reversed.
                if (!i_small_speaker_judgement_off) begin
                    next_flags[3 - c] = magnitude(i_result[c], i_magnitude_type_real_only)
                                        < {2'b00, i_small_speaker_threshold};
                end
            end
        end
        // Registered from the next misc value so the pin follows the write by one cycle.
        next_pullup_en = ~next_misc[load_diag_pkg::PULLUP_OFF_BIT];
        next_settle = settle_for(misc[load_diag_pkg::SETTLE_LSB +: 2]);
        next_scale  = i_measure_range_select ? 16'(load_diag_pkg::RANGE1_MOHM_PER_CODE)
                                             : 16'(load_diag_pkg::RANGE0_MOHM_PER_CODE);
        case (i_rd_addr)
            load_diag_pkg::CH2_LOAD_IMAG_OFS:       next_rd_data = result[1].reactance;
            load_diag_pkg::CH3_LOAD_REAL_OFS:       next_rd_data = result[2].resistance;
            load_diag_pkg::CH3_LOAD_IMAG_OFS:       next_rd_data = result[2].reactance;
            load_diag_pkg::CH4_LOAD_REAL_OFS:       next_rd_data = result[3].resistance;
            load_diag_pkg::CH4_LOAD_IMAG_OFS:       next_rd_data = result[3].reactance;
            load_diag_pkg::SMALL_SPEAKER_FLAGS_OFS: next_rd_data = {4'h0, flags};
            load_diag_pkg::MISC_CONTROL_THREE_OFS:  next_rd_data = misc;
            load_diag_pkg::SILICON_REVISION_OFS:    next_rd_data = REVISION_CODE;
            default:                                next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            for (int c = 0; c < 4; c++) begin
                result[c] <= '0;
            end
            flags       <= 4'h0;
            misc        <= load_diag_pkg::MISC_RESET;
            fault_clr   <= 1'b0;
            thermal_sd  <= 1'b0;
            started     <= 4'h0;
            start_pulse <= 4'h0;
            rd_data     <= 8'h00;
            settle      <= 32'h0;
            scale       <= 16'h0;
            pullup_en   <= 1'b1;
        end else begin
            result      <= next_result;
            flags       <= next_flags;
            misc        <= next_misc;
            fault_clr   <= next_fault_clr;
            thermal_sd  <= next_thermal_sd;
            started     <= next_started;
            start_pulse <= next_start_pulse;
            rd_data     <= next_rd_data;
            settle      <= next_settle;
            scale       <= next_scale;
            pullup_en   <= next_pullup_en;
        end
    end

    assign o_rd_data          = rd_data;
    assign o_measure_start    = start_pulse;
    assign o_fault_clear      = fault_clr;
    assign o_settle_cycles    = settle;
    assign o_thermal_shutdown = thermal_sd;
    assign o_gpio_pullup_en   = pullup_en;
    assign o_mohm_per_code    = scale;

    fault_strobe_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        o_fault_clear && !write_misc |=> !o_fault_clear && !misc[7])
        else $error("fault clear held beyond one cycle");
    fault_write_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        write_misc |=> o_fault_clear == $past(i_wr.wdata[7]))
        else $error("fault clear does not follow write");
    pullup_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        write_misc |=> o_gpio_pullup_en == !$past(i_wr.wdata[1]))
        else $error("pull-up enable wrong");
    settle_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        misc[5:4] == 2'h1 |=> o_settle_cycles == 32'(15 * SETTLE_MS_CYCLES))
        else $error("settle delay wrong");
    sequence hiz_go_s;
        i_measure_go[0] && i_channel_hiz[0] && !started[0];
    endsequence
    start_hiz_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        o_measure_start[0] |-> $past(i_channel_hiz[0]) && $past(i_measure_go[0]))
        else $error("start without high impedance");
    start_once_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        hiz_go_s |=> o_measure_start[0] ##1 !o_measure_start[0])
        else $error("start pulse wrong");
    resume_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        thermal_sd && !i_thermal_trip && !misc[3] && !fault_clr |=> thermal_sd)
        else $error("resumed without clear");
    scale_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        !i_measure_range_select |=> o_mohm_per_code == 16'(load_diag_pkg::RANGE0_MOHM_PER_CODE))
        else $error("range zero scale wrong");
    flags_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_rd_addr == load_diag_pkg::SMALL_SPEAKER_FLAGS_OFS |=> o_rd_data[7:4] == 4'h0)
        else $error("flag upper bits nonzero");
endmodule : load_diag_report_misc_regs
`default_nettype wire
